// file: hdl/casd_pkg.sv
// package: constants, command and memory carriers for the arithmetic and stack datapath
// Operation
// - exchange swaps acc and memory, flags kept
// - save writes flags and acc, pointer up 2
// - restore drops pointer 2, loads flags and acc
// - add immediate into acc, all flags updated
// - add memory into acc, all flags updated
// - add acc into memory, acc unchanged
// - add with carry into acc
// - add with carry into memory
// - acc plus carry only into acc
// - memory plus carry only into memory
// - negated acc plus memory into acc
// - negated memory plus acc into memory
// - subtract immediate from acc, all flags
// - subtract memory from acc, all flags
// - subtract acc from memory, into memory
// - acc minus memory minus carry into acc
// - memory minus acc minus carry into memory
// - acc minus carry only into acc
// - memory minus carry only into memory
// - memory move into acc sets zero only
package casd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int APB_AW = 8;

    // apb register byte addresses
    localparam logic [APB_AW-1:0] REG_ACC    = 8'h00;
    localparam logic [APB_AW-1:0] REG_FLAGS  = 8'h04;
    localparam logic [APB_AW-1:0] REG_SP     = 8'h08;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h0C;

    // reset values and pointer steps
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] SP_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0] SP_STEP   = 8'h02;
    localparam logic [ADDR_W-1:0] SP_HI_OFS = 8'h01;
    localparam int                STATUS_BUSY_BIT = 0;

    typedef enum logic [4:0] {
        OP_NOP, OP_XCH, OP_PUSHAF, OP_POPAF, OP_MOV_AM,
        OP_ADD_AI, OP_ADD_AM, OP_ADD_MA, OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A, OP_ADDC_M,
        OP_NADD_AM, OP_NADD_MA,
        OP_SUB_AI, OP_SUB_AM, OP_SUB_MA, OP_SUBC_AM, OP_SUBC_MA, OP_SUBC_A, OP_SUBC_M
    } casd_op_e;

    // flag byte: bit0 zero, bit1 carry, bit2 half carry, bit3 signed wrap
    typedef struct packed {
        logic signed_wrap_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic zero_flag;
    } casd_flags_s;

    localparam casd_flags_s FLAGS_RESET = 4'h0;

    typedef struct packed {
        casd_op_e          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] imm;
    } casd_cmd_s;

    typedef struct packed {
        logic              re;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } casd_mem_s;

    typedef struct packed {
        logic [DATA_W-1:0] res;
        casd_flags_s       flags;
    } casd_alu_s;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } casd_apb_req_s;

endpackage

// file: hdl/casd_datapath.sv
// module: arithmetic, exchange and stack datapath with apb register access
`timescale 1ns/1ns
module casd_datapath (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire casd_pkg::casd_apb_req_s apb_req,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    cmd_valid,
    input  wire casd_pkg::casd_cmd_s     cmd,
    output logic                         cmd_ready,
    output logic                         done,
    output casd_pkg::casd_mem_s          mem_req,
    input  wire logic [7:0]              mem_rdata,
    output logic [7:0]                   acc,
    output casd_pkg::casd_flags_s        flags,
    output logic [7:0]                   stack_ptr
);
    import casd_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_EXEC, ST_PUSH2, ST_POP_FLAG, ST_POP_ACC, ST_POP_END
    } casd_state_e;

    typedef struct packed {
        casd_state_e       state;
        casd_op_e          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] acc;
        casd_flags_s       flags;
        logic [ADDR_W-1:0] sp;
        casd_mem_s         mem;
        logic [31:0]       prdata;
        logic              done;
    } casd_regs_s;

    casd_regs_s st;
    casd_regs_s next_st;

    // add or subtract with carry in, flags from the 9-bit and nibble results
    function automatic casd_alu_s casd_alu(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] half;
        casd_alu_s  r;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            r.flags.signed_wrap_flag = (a[7] != b[7]) && (full[7] != a[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            r.flags.signed_wrap_flag = (a[7] == b[7]) && (full[7] != a[7]);
        end
        r.res                   = full[7:0];
        r.flags.carry_flag      = full[8];
        r.flags.half_carry_flag = half[4];
        r.flags.zero_flag       = (full[7:0] == 8'h00);
        return r;
    endfunction

    // ops whose result goes back to the memory byte
    function automatic logic casd_dest_mem(input casd_op_e op);
        return op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA,
                          OP_SUB_MA, OP_SUBC_MA, OP_SUBC_M};
    endfunction

    // ops that need no memory operand
    function automatic logic casd_no_mem(input casd_op_e op);
        return op inside {OP_NOP, OP_PUSHAF, OP_POPAF, OP_ADD_AI, OP_ADDC_A,
                          OP_SUB_AI, OP_SUBC_A};
    endfunction

    function automatic logic casd_reg_hit(input logic [APB_AW-1:0] a);
        return a inside {REG_ACC, REG_FLAGS, REG_SP, REG_STATUS};
    endfunction

    logic      accept;
    logic      apb_wr;
    casd_op_e  cur_op;
    logic [7:0] cur_imm;
    logic [7:0] opx;
    logic [7:0] opy;
    logic      opc;
    logic      opsub;
    casd_alu_s alu;

    assign cmd_ready = (st.state == ST_IDLE);
    assign accept    = cmd_valid && cmd_ready;
    assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign pready    = 1'b1;
    assign pslverr   = apb_req.psel && apb_req.penable && !casd_reg_hit(apb_req.paddr);
    assign cur_op    = accept ? cmd.op : st.op;
    assign cur_imm   = cmd.imm;

    // operand selection for the shared adder
    always_comb begin
        opx   = st.acc;
        opy   = mem_rdata;
        opc   = 1'b0;
        opsub = 1'b0;
        unique case (cur_op)
            OP_ADD_AI:  opy = cur_imm;
            OP_ADD_AM, OP_ADD_MA: opc = 1'b0;
            OP_ADDC_AM, OP_ADDC_MA: opc = st.flags.carry_flag;
            OP_ADDC_A: begin
                opy = 8'h00;
                opc = st.flags.carry_flag;
            end
            OP_ADDC_M: begin
                opx = mem_rdata;
                opy = 8'h00;
                opc = st.flags.carry_flag;
            end
            OP_NADD_AM: begin
                opx   = mem_rdata;
                opy   = st.acc;
                opsub = 1'b1;
            end
            OP_NADD_MA: opsub = 1'b1;
            OP_SUB_AI: begin
                opy   = cur_imm;
                opsub = 1'b1;
            end
            OP_SUB_AM: opsub = 1'b1;
            OP_SUB_MA: begin
                opx   = mem_rdata;
                opy   = st.acc;
                opsub = 1'b1;
            end
            OP_SUBC_AM: begin
                opc   = st.flags.carry_flag;
                opsub = 1'b1;
            end
            OP_SUBC_MA: begin
                opx   = mem_rdata;
                opy   = st.acc;
                opc   = st.flags.carry_flag;
                opsub = 1'b1;
            end
            OP_SUBC_A: begin
                opy   = 8'h00;
                opc   = st.flags.carry_flag;
                opsub = 1'b1;
            end
            OP_SUBC_M: begin
                opx   = mem_rdata;
                opy   = 8'h00;
                opc   = st.flags.carry_flag;
                opsub = 1'b1;
            end
            OP_NOP, OP_XCH, OP_PUSHAF, OP_POPAF, OP_MOV_AM: opc = 1'b0;
        endcase
        alu = casd_alu(opx, opy, opc, opsub);
    end

    // sequencer, datapath and register file
    always_comb begin
        next_st        = st;
        next_st.mem.re = 1'b0;
        next_st.mem.we = 1'b0;
        next_st.done   = 1'b0;
        unique case (st.state)
            ST_IDLE: begin
                if (accept) begin
                    next_st.op   = cmd.op;
                    next_st.addr = cmd.addr;
                    if (cmd.op == OP_PUSHAF) begin
                        next_st.mem.we    = 1'b1;
                        next_st.mem.addr  = st.sp;
                        next_st.mem.wdata = {4'h0, st.flags};
                        next_st.state     = ST_PUSH2;
                    end else if (cmd.op == OP_POPAF) begin
                        next_st.sp       = st.sp - SP_STEP;
                        next_st.mem.re   = 1'b1;
                        next_st.mem.addr = st.sp - SP_STEP;
                        next_st.state    = ST_POP_FLAG;
                    end else if (casd_no_mem(cmd.op)) begin
                        if (cmd.op != OP_NOP) begin
                            next_st.acc   = alu.res;
                            next_st.flags = alu.flags;
                        end
                        next_st.done = 1'b1;
                    end else begin
                        next_st.mem.re   = 1'b1;
                        next_st.mem.addr = cmd.addr;
                        next_st.state    = ST_READ;
                    end
                end
            end
            ST_READ: next_st.state = ST_EXEC;
            ST_EXEC: begin
                next_st.state = ST_IDLE;
                next_st.done  = 1'b1;
                if (st.op == OP_XCH) begin
                    next_st.mem.we    = 1'b1;
                    next_st.mem.addr  = st.addr;
                    next_st.mem.wdata = st.acc;
                    next_st.acc       = mem_rdata;
                end else if (st.op == OP_MOV_AM) begin
                    next_st.acc             = mem_rdata;
                    next_st.flags.zero_flag = (mem_rdata == 8'h00);
                end else if (casd_dest_mem(st.op)) begin
                    next_st.mem.we    = 1'b1;
                    next_st.mem.addr  = st.addr;
                    next_st.mem.wdata = alu.res;
                    next_st.flags     = alu.flags;
                end else begin
                    next_st.acc   = alu.res;
                    next_st.flags = alu.flags;
                end
            end
            ST_PUSH2: begin
                next_st.mem.we    = 1'b1;
                next_st.mem.addr  = st.sp + SP_HI_OFS;
                next_st.mem.wdata = st.acc;
                next_st.sp        = st.sp + SP_STEP;
                next_st.done      = 1'b1;
                next_st.state     = ST_IDLE;
            end
            ST_POP_FLAG: begin
                next_st.mem.re   = 1'b1;
                next_st.mem.addr = st.sp + SP_HI_OFS;
                next_st.state    = ST_POP_ACC;
            end
            ST_POP_ACC: begin
                next_st.flags = casd_flags_s'(mem_rdata[3:0]);
                next_st.state = ST_POP_END;
            end
            ST_POP_END: begin
                next_st.acc   = mem_rdata;
                next_st.done  = 1'b1;
                next_st.state = ST_IDLE;
            end
        endcase
        // register read data is captured in the setup cycle
        if (apb_req.psel && !apb_req.penable) begin
            unique case (apb_req.paddr)
                REG_ACC:    next_st.prdata = {24'h000000, st.acc};
                REG_FLAGS:  next_st.prdata = {28'h0000000, st.flags};
                REG_SP:     next_st.prdata = {24'h000000, st.sp};
                REG_STATUS: next_st.prdata = {31'h00000000, st.state != ST_IDLE};
                default:    next_st.prdata = 32'h00000000;
            endcase
        end
        // software writes take priority over the datapath in the same cycle
        if (apb_wr) begin
            unique case (apb_req.paddr)
                REG_ACC:   next_st.acc   = apb_req.pwdata[7:0];
                REG_FLAGS: next_st.flags = casd_flags_s'(apb_req.pwdata[3:0]);
                REG_SP:    next_st.sp    = apb_req.pwdata[7:0];
                default:   next_st.sp    = next_st.sp;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.state  <= ST_IDLE;
            st.op     <= OP_NOP;
            st.acc    <= ACC_RESET;
            st.flags  <= FLAGS_RESET;
            st.sp     <= SP_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata    = st.prdata;
    assign done      = st.done;
    assign mem_req   = st.mem;
    assign acc       = st.acc;
    assign flags     = st.flags;
    assign stack_ptr = st.sp;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // qualifiers shared by the result checks
    logic       exec_cyc;
    logic [7:0] carry_byte;
    assign exec_cyc   = (st.state == ST_EXEC) && !apb_wr;
    assign carry_byte = {7'h00, st.flags.carry_flag};

    a_xch_swap: assert property (exec_cyc && (st.op == OP_XCH) |=>
        mem_req.we && (mem_req.wdata == $past(st.acc)) && (st.acc == $past(mem_rdata))
        && (st.flags == $past(st.flags)))
        else $error("exchange did not swap acc and memory");

    a_push_pair: assert property (accept && (cmd.op == OP_PUSHAF) && !apb_wr |=>
        mem_req.we && (mem_req.addr == $past(st.sp)) ##1
        mem_req.we && (st.sp == 8'($past(st.sp, 2) + SP_STEP)) && done)
        else $error("save did not write pair and step pointer");

    a_pop_step: assert property (accept && (cmd.op == OP_POPAF) && !apb_wr |=>
        (st.sp == 8'($past(st.sp) - SP_STEP)) && mem_req.re && (mem_req.addr == st.sp)
        ##3 done)
        else $error("restore did not drop pointer by two");

    a_add_imm: assert property (accept && (cmd.op == OP_ADD_AI) && !apb_wr |=>
        (st.acc == 8'($past(st.acc) + $past(cmd.imm))) && done)
        else $error("add immediate result wrong");

    a_addc_acc: assert property (accept && (cmd.op == OP_ADDC_A) && !apb_wr |=>
        st.acc == 8'($past(st.acc) + {7'h00, $past(st.flags.carry_flag)}))
        else $error("acc plus carry result wrong");

    a_sub_borrow: assert property (accept && (cmd.op == OP_SUB_AI) && !apb_wr |=>
        st.flags.carry_flag == ($past(st.acc) < $past(cmd.imm)))
        else $error("subtract borrow flag wrong");

    a_mem_dest: assert property (exec_cyc && casd_dest_mem(st.op) |=>
        mem_req.we && (mem_req.addr == $past(st.addr)) && $stable(st.acc))
        else $error("memory destination op touched acc or skipped write");

    a_mov_zero: assert property (exec_cyc && (st.op == OP_MOV_AM) |=>
        (st.flags.zero_flag == (st.acc == 8'h00)) && $stable(st.flags.carry_flag)
        && $stable(st.flags.half_carry_flag) && $stable(st.flags.signed_wrap_flag))
        else $error("memory move flags wrong");

    a_add_mem: assert property (exec_cyc && (st.op == OP_ADD_AM) |=>
        st.acc == 8'($past(st.acc) + $past(mem_rdata)))
        else $error("add memory into acc wrong");

    a_add_wr: assert property (exec_cyc && (st.op == OP_ADD_MA) |=>
        mem_req.wdata == 8'($past(st.acc) + $past(mem_rdata)))
        else $error("add acc into memory wrong");

    a_addc_am: assert property (exec_cyc && (st.op == OP_ADDC_AM) |=>
        st.acc == 8'($past(st.acc) + $past(mem_rdata) + $past(carry_byte)))
        else $error("add with carry into acc wrong");

    a_addc_ma: assert property (exec_cyc && (st.op == OP_ADDC_MA) |=>
        mem_req.wdata == 8'($past(st.acc) + $past(mem_rdata) + $past(carry_byte)))
        else $error("add with carry into memory wrong");

    a_addc_m: assert property (exec_cyc && (st.op == OP_ADDC_M) |=>
        mem_req.wdata == 8'($past(mem_rdata) + $past(carry_byte)))
        else $error("memory plus carry wrong");

    a_nadd_am: assert property (exec_cyc && (st.op == OP_NADD_AM) |=>
        st.acc == 8'($past(mem_rdata) - $past(st.acc)))
        else $error("negated acc plus memory wrong");

    a_nadd_ma: assert property (exec_cyc && (st.op == OP_NADD_MA) |=>
        mem_req.wdata == 8'($past(st.acc) - $past(mem_rdata)))
        else $error("negated memory plus acc wrong");

    a_sub_imm: assert property (accept && (cmd.op == OP_SUB_AI) && !apb_wr |=>
        st.acc == 8'($past(st.acc) - $past(cmd.imm)))
        else $error("subtract immediate result wrong");

    a_sub_am: assert property (exec_cyc && (st.op == OP_SUB_AM) |=>
        st.acc == 8'($past(st.acc) - $past(mem_rdata)))
        else $error("subtract memory from acc wrong");

    a_sub_ma: assert property (exec_cyc && (st.op == OP_SUB_MA) |=>
        mem_req.wdata == 8'($past(mem_rdata) - $past(st.acc)))
        else $error("subtract acc from memory wrong");

    a_subc_am: assert property (exec_cyc && (st.op == OP_SUBC_AM) |=>
        st.acc == 8'($past(st.acc) - $past(mem_rdata) - $past(carry_byte)))
        else $error("subtract with borrow into acc wrong");

    a_subc_ma: assert property (exec_cyc && (st.op == OP_SUBC_MA) |=>
        mem_req.wdata == 8'($past(mem_rdata) - $past(st.acc) - $past(carry_byte)))
        else $error("subtract with borrow into memory wrong");

    a_subc_a: assert property (accept && (cmd.op == OP_SUBC_A) && !apb_wr |=>
        st.acc == 8'($past(st.acc) - $past(carry_byte)))
        else $error("acc minus carry wrong");

    a_subc_m: assert property (exec_cyc && (st.op == OP_SUBC_M) |=>
        mem_req.wdata == 8'($past(mem_rdata) - $past(carry_byte)))
        else $error("memory minus carry wrong");

endmodule

// file: tb/casd_mem_model.sv
// partner model: byte-wide data memory with one-cycle read latency
`timescale 1ns/1ns
module casd_mem_model (
    input  wire logic                sys_clk,
    input  wire casd_pkg::casd_mem_s mem_req,
    output logic [7:0]               mem_rdata
);
    import casd_pkg::*;
    logic [7:0] mem [256];
    initial begin
        mem_rdata = 8'hA5;
    end
    // read data is valid only in the cycle after the read pulse
    // outside that cycle the data lines toggle, so a late sample shows up
    always @(posedge sys_clk) begin
        if (mem_req.we) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        if (mem_req.re) begin
            mem_rdata <= mem[mem_req.addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// file: tb/tb.sv
// testbench: register access, corner and random commands with result and flag checks
`timescale 1ns/1ns
module tb;
    import casd_pkg::*;
    typedef struct packed {
        casd_op_e   op;
        logic [7:0] a;
        logic [3:0] f;
        logic [7:0] m;
        logic [7:0] imm;
    } casd_tb_case_s;
    logic          sys_clk;
    logic          rst_n;
    casd_apb_req_s apb_req;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          cmd_valid;
    casd_cmd_s     cmd;
    logic          cmd_ready;
    logic          done;
    casd_mem_s     mem_req;
    logic [7:0]    mem_rdata;
    logic [7:0]    acc;
    casd_flags_s   flags;
    logic [7:0]    stack_ptr;
    int            n_mismatch;
    int            compares;
    int            seed;
    int            k;
    logic [7:0]    ea;
    casd_flags_s   ef;
    logic [7:0]    esp;
    logic [7:0]    em [256];
    logic [31:0]   rd;
    logic          err;
    casd_tb_case_s tc;
    localparam casd_tb_case_s CORNER [18] = '{
        '{OP_ADD_AI,  8'hFF, 4'h0, 8'h00, 8'h01},
        '{OP_ADD_AM,  8'h7F, 4'h0, 8'h01, 8'h00},
        '{OP_ADD_MA,  8'h80, 4'h0, 8'h80, 8'h00},
        '{OP_ADDC_AM, 8'h0F, 4'h2, 8'hF0, 8'h00},
        '{OP_ADDC_MA, 8'h01, 4'h2, 8'hFE, 8'h00},
        '{OP_ADDC_A,  8'hFF, 4'h2, 8'h00, 8'h00},
        '{OP_ADDC_M,  8'h00, 4'h2, 8'h7F, 8'h00},
        '{OP_NADD_AM, 8'h05, 4'h0, 8'h03, 8'h00},
        '{OP_NADD_MA, 8'h80, 4'h0, 8'h01, 8'h00},
        '{OP_SUB_AI,  8'h00, 4'h0, 8'h00, 8'h01},
        '{OP_SUB_AM,  8'h80, 4'h0, 8'h01, 8'h00},
        '{OP_SUB_MA,  8'h10, 4'h0, 8'h10, 8'h00},
        '{OP_SUBC_AM, 8'h10, 4'h2, 8'h0F, 8'h00},
        '{OP_SUBC_MA, 8'h00, 4'h2, 8'h00, 8'h00},
        '{OP_SUBC_A,  8'h00, 4'h2, 8'h00, 8'h00},
        '{OP_SUBC_M,  8'h00, 4'h2, 8'h80, 8'h00},
        '{OP_XCH,     8'h5A, 4'hF, 8'hA5, 8'h00},
        '{OP_MOV_AM,  8'h33, 4'hE, 8'h00, 8'h00}
    };

    casd_datapath uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .done(done), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .acc(acc), .flags(flags), .stack_ptr(stack_ptr)
    );
    casd_mem_model mem_i (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [11:0] alu(input logic [7:0] x, input logic [7:0] y,
                                        input logic ci, input logic sub);
        logic [8:0] s;
        logic [4:0] h;
        logic       v;
        if (sub) begin
            s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
            h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
            v = (x[7] != y[7]) && (s[7] != x[7]);
        end else begin
            s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
            h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
            v = (x[7] == y[7]) && (s[7] != x[7]);
        end
        return {v, h[4], s[8], s[7:0] == 8'h00, s[7:0]};
    endfunction

    function automatic int lat(input casd_op_e op);
        case (op)
            OP_NOP, OP_ADD_AI, OP_SUB_AI, OP_ADDC_A, OP_SUBC_A: return 1;
            OP_PUSHAF: return 2;
            OP_POPAF: return 4;
            default: return 3;
        endcase
    endfunction

    task automatic predict(input casd_op_e op, input logic [7:0] a, input logic [7:0] imm);
        logic [7:0]  m;
        logic [11:0] r;
        logic        c;
        m = em[a];
        c = ef.carry_flag;
        r = {ef, ea};
        case (op)
            OP_XCH: begin em[a] = ea; ea = m; end
            OP_MOV_AM: begin ea = m; ef.zero_flag = (m == 8'h00); end
            OP_PUSHAF: begin em[esp] = {4'h0, ef}; em[esp + 8'h01] = ea; esp += 8'h02; end
            OP_POPAF: begin esp -= 8'h02; ef = em[esp][3:0]; ea = em[esp + 8'h01]; end
            OP_ADD_AI: r = alu(ea, imm, 1'b0, 1'b0);
            OP_ADD_AM, OP_ADD_MA: r = alu(ea, m, 1'b0, 1'b0);
            OP_ADDC_AM, OP_ADDC_MA: r = alu(ea, m, c, 1'b0);
            OP_ADDC_A: r = alu(ea, 8'h00, c, 1'b0);
            OP_ADDC_M: r = alu(m, 8'h00, c, 1'b0);
            OP_NADD_AM, OP_SUB_MA: r = alu(m, ea, 1'b0, 1'b1);
            OP_NADD_MA, OP_SUB_AM: r = alu(ea, m, 1'b0, 1'b1);
            OP_SUB_AI: r = alu(ea, imm, 1'b0, 1'b1);
            OP_SUBC_AM: r = alu(ea, m, c, 1'b1);
            OP_SUBC_MA: r = alu(m, ea, c, 1'b1);
            OP_SUBC_A: r = alu(ea, 8'h00, c, 1'b1);
            OP_SUBC_M: r = alu(m, 8'h00, c, 1'b1);
            default: ;
        endcase
        if (op >= OP_ADD_AI) begin
            if (op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA, OP_SUB_MA,
                           OP_SUBC_MA, OP_SUBC_M}) begin
                em[a] = r[7:0];
            end else begin
                ea = r[7:0];
            end
            ef = r[11:8];
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask

    task automatic setaf(input logic [7:0] a, input logic [3:0] f);
        apb(1'b1, REG_ACC, {24'h0, a});
        apb(1'b1, REG_FLAGS, {28'h0, f});
        ea = a;
        ef = f;
    endtask

    task automatic run(input casd_op_e op, input logic [7:0] addr, input logic [7:0] imm);
        int n;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, addr: addr, imm: imm};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        if (cmd_ready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (done !== 1'b1 && n < 50);
        if (done !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        chk("latency", lat(op), n);
        predict(op, addr, imm);
        chk("acc", {24'h0, ea}, {24'h0, acc});
        chk("flags", {28'h0, ef}, {28'h0, flags});
        chk("stack_ptr", {24'h0, esp}, {24'h0, stack_ptr});
        #1;
        chk("memory", {24'h0, em[addr]}, {24'h0, mem_i.mem[addr]});
    endtask

    initial begin
        seed = 14673;
        rst_n = 1'b0;
        apb_req = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        n_mismatch = 0;
        compares = 0;
        for (int i = 0; i < 256; i++) begin
            em[i] = 8'($random(seed));
            mem_i.mem[i] = em[i];
        end
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_ACC, 32'h0);
        chk("acc reset", {24'h0, ACC_RESET}, rd);
        chk("mapped err", 32'h0, {31'h0, err});
        chk("sp reset", {24'h0, SP_RESET}, {24'h0, stack_ptr});
        apb(1'b0, REG_FLAGS, 32'h0);
        chk("flags reset", {28'h0, FLAGS_RESET}, rd);
        apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, 8'h10, 32'h0000_00AA);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, REG_SP, 32'h0000_00FE);
        apb(1'b0, REG_SP, 32'h0);
        chk("sp rw", 32'h0000_00FE, rd);
        esp = 8'hFE;
        setaf(8'hC3, 4'h5);
        run(OP_PUSHAF, 8'h00, 8'h00);
        chk("push flags", {28'h0, em[8'hFE][3:0]}, {28'h0, mem_i.mem[8'hFE][3:0]});
        chk("push acc", {24'h0, em[8'hFF]}, {24'h0, mem_i.mem[8'hFF]});
        setaf(8'h00, 4'hA);
        run(OP_POPAF, 8'h00, 8'h00);
        for (int i = 0; i < 18; i++) begin
            tc = CORNER[i];
            setaf(tc.a, tc.f);
            mem_i.mem[8'h40] = tc.m;
            em[8'h40] = tc.m;
            run(tc.op, 8'h40, tc.imm);
        end
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0) begin
                setaf(8'($random(seed)), 4'($random(seed)));
            end
            k = $unsigned($random(seed)) % 21;
            if (k == 2 || k == 3) begin
                k = 4;
            end
            run(casd_op_e'(k), 8'($random(seed)), 8'($random(seed)));
        end
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        ea = ACC_RESET;
        chk("sp reset again", {24'h0, SP_RESET}, {24'h0, stack_ptr});
        chk("flags reset again", {28'h0, FLAGS_RESET}, {28'h0, flags});
        apb(1'b0, REG_ACC, 32'h0);
        chk("acc read", {24'h0, ea}, rd);
        tally_and_finish();
    end
endmodule
